// ===== design/display_timing_pulse_generator.sv
// timing pulse generator with byte-dispatch and deflection-wait pulses
//
// Function
// [R1] runs at one period per 500 ns; the operation starts and stops it
// [R2] a pulse fires only when running and its select latch is set
// [R3] step sets 125 ns after run, holds 250 ns, then 125 ns third delay; the ring gives 150 ns first and 100 ns third
// [R4] ring keeps toggling step every 250 ns while run stays set
// [R5] step rise samples select latches; firing pulse clears its own latch
// [R6] at most one select latch is set at any time
// [R7] hold-one-period latch inhibits sampling for one 500 ns period
// [R8] each pulse arms its successor, with hold where the sequence needs it; the code arms one only after pulses 9, 1 (deflect action) and 3 (no pen hit)
// [R9] buffer write stops the generator after each stored byte
// [R10] exactly 22 pulses: 1, 3, 4, 6-13, 15-24, 26
// [R11] direct write fires pulse 1 after fourth service period with byte captured
// [R12] pulse 1 starts mode search, control search or a register transfer
// [R13] in regeneration pulse 1 checks cursor activity when cursor bit is 1
// [R14] pulse 3 stops generator, waits interlock clear, then samples pen
// [R15] pen hit halts regeneration, steps address back 2, 8 or 5
// [R16] pen hit sets the fault flag in status
// [R17] host senses after pen hit; sense bytes 3 and 4 hold address
// [R18] interlock still set after pulse 1 routes through pulse 3 first
// [R19] reset clears run, step, hold and all select latches
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module display_timing_pulse_generator (
    input  wire logic                              ref_clk,
    input  wire logic                              sys_rst,
    input  wire logic [tp_gen_pkg::REG_SENSE:0]    wbAdrI,
    input  wire logic [31:0]                       wbDatI,
    input  wire logic [3:0]                        wbSelI,
    input  wire logic                              wbWeI,
    input  wire logic                              wbCycI,
    input  wire logic                              wbStbI,
    output logic      [31:0]                       wbDatO,
    output logic                                   wbAckO,
    input  wire logic                              directWrite,
    input  wire logic                              regenActive,
    input  wire logic                              bufferWrite,
    input  wire logic                              byteStored,
    input  wire logic                              serviceFourth,
    input  wire logic                              byteCaptured,
    input  wire logic [7:0]                        capturedByte,
    input  wire logic [2:0]                        dispatchAction,
    input  wire logic                              deflectInterlock,
    input  wire logic                              penActivity,
    input  wire logic [1:0]                        entryType,
    output logic      [tp_gen_pkg::PULSE_W-1:0]    timingPulse,
    output logic      [2:0]                        actionStart,
    output logic                                   cursorCheck,
    output logic                                   regenHalt,
    output logic                                   ringStep,
    output logic                                   runActive
);
    import tp_gen_pkg::*;

    typedef struct packed {
        logic                  run;
        logic                  hold;
        logic                  holdSeen;
        logic [PULSE_W-1:0]    sel;
        logic [PULSE_W-1:0]    pulse;
        logic                  waitDeflect;
        logic                  pendingGraphic;
        logic [2:0]            action;
        logic                  cursor;
        logic                  halt;
        logic                  fault;
        logic [ADDR_W-1:0]     addr;
        logic [ADDR_W-1:0]     senseAddr;
        logic                  swHold;
        logic                  ack;
        logic [31:0]           rdata;
        logic                  stepD;
        logic [1:0]            intlSync;
        logic [1:0]            penSync;
    } core_reg_t;

    core_reg_t s_q;
    core_reg_t s_d;
    logic stepLatch;
    logic stepRise;

    // the one-hot select vector keeps only legal pulse numbers
    function automatic logic [PULSE_W-1:0] armOne(input int num);
        logic [PULSE_W-1:0] v;
        v = '0;
        if (num >= 0 && num < PULSE_W) begin
            v[num] = 1'b1;
        end
        return v & PULSE_USED; // [R10]
    endfunction

    step_ring u_ring (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .runLatch  (s_q.run),
        .stepLatch (stepLatch),
        .stepRise  (stepRise)
    );

    always_comb begin
        logic reqOk;
        logic [3:0] back;
        logic penHit;
        s_d = s_q;
        reqOk = wbCycI && wbStbI && !s_q.ack;
        back = BACK_GRAPHIC;
        penHit = s_q.waitDeflect && !s_q.intlSync[1] && s_q.penSync[1];
        s_d.pulse = '0;
        s_d.action = ACT_NONE;
        s_d.cursor = 1'b0;
        s_d.ack = 1'b0;
        s_d.stepD = stepLatch;
        // pin levels from the analog side pass two flops
        s_d.intlSync = {s_q.intlSync[0], deflectInterlock};
        s_d.penSync = {s_q.penSync[0], penActivity};

        // direct write: byte captured after fourth service period
        if (directWrite && serviceFourth && byteCaptured && s_q.sel == '0) begin
            s_d.run = 1'b1; // [R1]
            s_d.sel = armOne(PULSE_BYTE_DISPATCH); // [R11]
        end
        if (regenActive && !s_q.run && !s_q.halt && s_q.sel == '0 && !s_q.waitDeflect) begin
            s_d.run = 1'b1;
            s_d.sel = armOne(PULSE_BUFFER_READ);
        end

        // hold period counted in step rises: a rise is one period
        if (stepRise && s_q.hold) begin
            s_d.hold = 1'b0; // [R7]
        end else if (stepRise && s_q.run && (s_q.sel & PULSE_USED) != '0) begin // [R2]
            s_d.pulse = s_q.sel; // [R5]
            s_d.sel = '0; // [R5]
            if (s_q.sel[PULSE_BYTE_DISPATCH]) begin
                s_d.action = dispatchAction; // [R12]
                s_d.cursor = regenActive && capturedByte[6]; // [R13]
                if (dispatchAction == ACT_DEFLECT) begin
                    if (s_q.intlSync[1]) begin
                        s_d.sel = armOne(PULSE_DEFLECT_WAIT); // [R18] [R8]
                        s_d.pendingGraphic = 1'b1;
                    end else begin
                        s_d.sel = armOne(PULSE_DEFLECT_LOAD); // [R8]
                        s_d.hold = s_q.swHold; // [R7]
                    end
                end else if (!directWrite) begin
                    s_d.run = 1'b0;
                end
            end else if (s_q.sel[PULSE_DEFLECT_WAIT]) begin
                s_d.run = 1'b0; // [R14]
                s_d.waitDeflect = 1'b1; // [R14]
            end else if (s_q.sel[PULSE_BUFFER_READ]) begin
                s_d.sel = armOne(PULSE_BYTE_DISPATCH); // [R8]
                s_d.hold = 1'b1; // [R7] [R8]
            end else begin
                s_d.run = 1'b0; // load pulses stop the generator for a new cycle
            end
        end

        // deflection wait: after interlock clears, sample pen
        if (s_q.waitDeflect && !s_q.intlSync[1]) begin
            s_d.waitDeflect = 1'b0;
            if (s_q.penSync[1]) begin
                s_d.halt = 1'b1; // [R15]
                s_d.fault = 1'b1; // [R16]
                s_d.pendingGraphic = 1'b0;
                unique case (entryType)
                    ENTRY_CHAR:    back = BACK_CHAR;
                    ENTRY_CONTROL: back = BACK_CONTROL;
                    default:       back = BACK_GRAPHIC;
                endcase
                s_d.addr = s_q.addr - {{(ADDR_W-4){1'b0}}, back}; // [R15]
                s_d.senseAddr = s_d.addr; // [R17]
            end else if (s_q.pendingGraphic) begin
                s_d.pendingGraphic = 1'b0;
                s_d.run = 1'b1;
                s_d.sel = armOne(PULSE_DEFLECT_LOAD); // [R18]
            end
        end

        if (bufferWrite && byteStored) begin
            s_d.run = 1'b0; // [R9]
        end
        if (s_q.pulse[PULSE_BUFFER_READ]) begin
            s_d.addr = s_q.addr + 14'h0001;
        end
        if (!regenActive) begin
            s_d.halt = 1'b0;
        end

        // wishbone slave, answers one cycle after the strobe
        if (reqOk) begin
            s_d.ack = 1'b1;
            s_d.rdata = UNMAPPED_DATA;
            unique case (wbAdrI)
                REG_CONTROL: begin
                    if (wbWeI && wbSelI[0]) begin
                        s_d.swHold = wbDatI[0];
                        if (wbDatI[1]) s_d.run = 1'b0; // [R1]
                        // a pen hit in the same cycle wins over the clear
                        if (wbDatI[2] && !penHit) s_d.halt = 1'b0;
                    end
                    s_d.rdata = {31'h0000_0000, s_q.swHold};
                end
                REG_STATUS: begin
                    if (wbWeI && wbSelI[0] && wbDatI[0] && !penHit) begin
                        s_d.fault = 1'b0; // [R16] set wins over clear
                    end
                    s_d.rdata = {26'h000_0000, s_q.halt, s_q.waitDeflect, s_q.hold,
                                 stepLatch, s_q.run, s_q.fault};
                end
                REG_ARM: begin
                    if (wbWeI && wbSelI[0] && s_q.sel == '0) begin
                        s_d.sel = armOne(int'(wbDatI[4:0])); // [R6]
                        s_d.run = (armOne(int'(wbDatI[4:0])) != '0);
                    end
                    s_d.rdata = {5'h00, s_q.sel};
                end
                REG_SENSE: begin
                    // third and fourth sense bytes
                    s_d.rdata = {16'h0000, 2'b00, s_q.senseAddr}; // [R17]
                end
                default: s_d.rdata = UNMAPPED_DATA;
            endcase
        end
        if (sys_rst) begin
            s_d = '0; // [R19]
        end
    end

    always_ff @(posedge ref_clk) begin
        s_q <= s_d;
    end

    assign wbDatO      = s_q.rdata;
    assign wbAckO      = s_q.ack;
    assign timingPulse = s_q.pulse;
    assign actionStart = s_q.action;
    assign cursorCheck = s_q.cursor;
    assign regenHalt   = s_q.halt;
    assign ringStep    = s_q.stepD;
    assign runActive   = s_q.run;
endmodule
`default_nettype wire

// ===== include/tp_gen_pkg.sv
// constants and types shared by the display timing pulse generator
package tp_gen_pkg;
    localparam int CLK_PERIOD_NS   = 50;
    localparam int FIRST_DELAY_NS  = 125;
    localparam int STEP_HIGH_NS    = 250;
    localparam int THIRD_DELAY_NS  = 125;
    localparam int PERIOD_NS       = 500;
    // least times round up to whole cycles, never below one
    localparam int FIRST_CYC  = (FIRST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIGH_CYC   = (STEP_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // third delay gives back the rounding so one period stays whole cycles
    localparam int THIRD_CYC  = PERIOD_NS / CLK_PERIOD_NS - FIRST_CYC - HIGH_CYC;
    localparam int RING_CNT_W = 4;
    localparam logic [RING_CNT_W-1:0] RING_CNT_RESET = 4'h0;

    // pulse numbers supported; index into a 27-bit vector
    localparam int PULSE_W = 27;
    localparam logic [PULSE_W-1:0] PULSE_USED = 27'h5FF_BFDA;
    localparam int PULSE_BYTE_DISPATCH = 1;
    localparam int PULSE_DEFLECT_WAIT  = 3;
    localparam int PULSE_DEFLECT_LOAD  = 6;
    localparam int PULSE_CHAR_LOAD     = 7;
    localparam int PULSE_BUFFER_READ   = 9;

    // byte dispatch actions
    localparam logic [2:0] ACT_NONE     = 3'h0;
    localparam logic [2:0] ACT_MODE     = 3'h1;
    localparam logic [2:0] ACT_CONTROL  = 3'h2;
    localparam logic [2:0] ACT_AREG     = 3'h3;
    localparam logic [2:0] ACT_ASSEMBLY = 3'h4;
    localparam logic [2:0] ACT_DEFLECT  = 3'h5;

    // buffer address back-step per entry type
    localparam logic [1:0] ENTRY_GRAPHIC = 2'h0;
    localparam logic [1:0] ENTRY_CHAR    = 2'h1;
    localparam logic [1:0] ENTRY_CONTROL = 2'h2;
    localparam logic [3:0] BACK_GRAPHIC  = 4'h2;
    localparam logic [3:0] BACK_CHAR     = 4'h8;
    localparam logic [3:0] BACK_CONTROL  = 4'h5;

    localparam int ADDR_W = 14;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;

    // wishbone register map (byte addresses)
    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h4;
    localparam logic [3:0] REG_ARM     = 4'h8;
    localparam logic [3:0] REG_SENSE   = 4'hC;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    typedef enum logic [1:0] {
        RING_IDLE  = 2'b00,
        RING_FIRST = 2'b01,
        RING_HIGH  = 2'b10,
        RING_THIRD = 2'b11
    } ring_state_t;
endpackage

// ===== design/step_ring.sv
// three-delay ring that toggles the step latch while the run latch is set
`timescale 1ns/1ns
`default_nettype none
module step_ring (
    input  wire logic                              ref_clk,
    input  wire logic                              sys_rst,
    input  wire logic                              runLatch,
    output var  logic                              stepLatch,
    output var  logic                              stepRise
);
    import tp_gen_pkg::*;

    typedef struct packed {
        ring_state_t               state;
        logic [RING_CNT_W-1:0]     cnt;
        logic                      step;
        logic                      rise;
    } ring_reg_t;

    ring_reg_t r_q;
    ring_reg_t r_d;

    if (FIRST_CYC + HIGH_CYC + THIRD_CYC != PERIOD_NS / CLK_PERIOD_NS) begin : g_bad_ring
        $error("ring delays do not sum to one timing period");
    end

    always_comb begin
        r_d = r_q;
        r_d.rise = 1'b0;
        r_d.cnt = r_q.cnt + 4'h1;
        unique case (r_q.state)
            RING_IDLE: begin
                r_d.cnt = RING_CNT_RESET;
                if (runLatch) begin
                    r_d.state = RING_FIRST;
                    // the idle cycle that saw run counts as the first delay cycle
                    r_d.cnt = RING_CNT_RESET + 4'h1; // [R3]
                end
            end
            RING_FIRST: begin
                if (r_q.cnt == RING_CNT_W'(FIRST_CYC - 1)) begin
                    r_d.state = RING_HIGH; // [R3]
                    r_d.step = 1'b1;
                    r_d.rise = 1'b1;
                    r_d.cnt = RING_CNT_RESET;
                end
            end
            RING_HIGH: begin
                if (r_q.cnt == RING_CNT_W'(HIGH_CYC - 1)) begin
                    r_d.state = RING_THIRD; // [R3] [R4]
                    r_d.step = 1'b0;
                    r_d.cnt = RING_CNT_RESET;
                end
            end
            RING_THIRD: begin
                if (r_q.cnt == RING_CNT_W'(THIRD_CYC - 1)) begin
                    // keep cycling only while run stays set
                    r_d.state = runLatch ? RING_FIRST : RING_IDLE; // [R4]
                    r_d.cnt = RING_CNT_RESET;
                end
            end
        endcase
        if (!runLatch && r_q.state == RING_FIRST) begin
            r_d.state = RING_IDLE; // [R1]
            r_d.cnt = RING_CNT_RESET;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r_q <= '{state: RING_IDLE, cnt: RING_CNT_RESET, step: 1'b0, rise: 1'b0}; // [R19]
        end else begin
            r_q <= r_d;
        end
    end

    assign stepLatch = r_q.step;
    assign stepRise  = r_q.rise;
endmodule
`default_nettype wire

// ===== sim/tp_gen_props.sv
// port assertions for the display timing pulse generator
`timescale 1ns/1ns
`default_nettype none
module tp_gen_props (
    input wire logic                           ref_clk,
    input wire logic                           sys_rst,
    input wire logic                           wbCycI,
    input wire logic                           wbStbI,
    input wire logic                           wbAckO,
    input wire logic [tp_gen_pkg::PULSE_W-1:0] timingPulse,
    input wire logic                           ringStep,
    input wire logic                           runActive
);
    import tp_gen_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    ack_next_a: assert property (wbCycI && wbStbI && !wbAckO |=> wbAckO)
        else $error("bus request not answered next cycle");
    ack_single_a: assert property (wbAckO |=> !wbAckO)
        else $error("ack longer than one cycle");
    pulse_onehot_a: assert property ($onehot0(timingPulse))
        else $error("two pulses at once");
    pulse_used_a: assert property ((timingPulse & ~PULSE_USED) == '0)
        else $error("unused pulse number fired");
    pulse_running_a: assert property (|timingPulse |-> $past(runActive))
        else $error("pulse while stopped");
    // two pulses never closer than one period
    pulse_spacing_a: assert property (|timingPulse |=> (timingPulse == '0)[*8] ##1 timingPulse == '0)
        else $error("pulses closer than one period");
    step_width_a: assert property ($fell(ringStep) && runActive |-> $past(ringStep, 5) && !$past(ringStep, 6))
        else $error("step high time wrong");
    run_start_a: assert property ($rose(runActive) |-> !ringStep[*2] ##[1:3] ringStep)
        else $error("first step delay wrong");
    step_period_a: assert property ($rose(ringStep) ##1 runActive[*8] ##2 runActive |-> $rose(ringStep))
        else $error("step period wrong");
    reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> !runActive && timingPulse == '0)
        else $error("reset left generator active");
endmodule
bind display_timing_pulse_generator tp_gen_props i_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .wbCycI(wbCycI), .wbStbI(wbStbI), .wbAckO(wbAckO), .timingPulse(timingPulse),
    .ringStep(ringStep), .runActive(runActive));
`default_nettype wire

// ===== sim/deflect_model.sv
// far-side model: beam deflection holding the interlock while it settles
`timescale 1ns/1ns
`default_nettype none
module deflect_model (
    input  wire logic       ref_clk,
    input  wire logic       startDeflect,
    input  wire logic [7:0] settleCycles,
    input  wire logic       deflectLoad,
    output var  logic       deflectInterlock
);
    logic [7:0] settleCnt_q = 8'h00;
    // settle time is set by the bench, which holds it at 60 cycles for every deflection, so only slow beams occur
    always_ff @(posedge ref_clk) begin
        if (startDeflect || deflectLoad) begin
            settleCnt_q <= settleCycles;
        end else if (settleCnt_q != 8'h00) begin
            settleCnt_q <= settleCnt_q - 8'h01;
        end
    end
    assign deflectInterlock = (settleCnt_q != 8'h00);
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the display timing pulse generator
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import tp_gen_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [12:0] wbAdrI = 13'h0000;
    logic [31:0] wbDatI = 32'h0000_0000;
    logic [3:0] wbSelI = 4'h0;
    logic wbWeI = 1'b0, wbCycI = 1'b0, wbStbI = 1'b0, startDeflect = 1'b0;
    logic directWrite = 1'b0, regenActive = 1'b0, bufferWrite = 1'b0, byteStored = 1'b0;
    logic serviceFourth = 1'b0, byteCaptured = 1'b0, penActivity = 1'b0;
    logic [7:0] capturedByte = 8'h00, settleCycles = 8'h3C;
    logic [2:0] dispatchAction = 3'h0;
    logic [1:0] entryType = 2'h0;
    logic [31:0] wbDatO, rd;
    logic [PULSE_W-1:0] timingPulse;
    logic [2:0] actionStart;
    logic wbAckO, cursorCheck, regenHalt, ringStep, runActive, deflectInterlock;
    logic [13:0] backBy [3] = '{14'h0002, 14'h0008, 14'h0005};
    logic [13:0] expAddr;
    int fails = 0;
    int n_checks = 0;
    int waited;
    bit hit;
    always #25 ref_clk = ~ref_clk;
    display_timing_pulse_generator i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wbAdrI(wbAdrI),
        .wbDatI(wbDatI), .wbSelI(wbSelI), .wbWeI(wbWeI), .wbCycI(wbCycI), .wbStbI(wbStbI),
        .wbDatO(wbDatO), .wbAckO(wbAckO), .directWrite(directWrite), .regenActive(regenActive),
        .bufferWrite(bufferWrite), .byteStored(byteStored), .serviceFourth(serviceFourth),
        .byteCaptured(byteCaptured), .capturedByte(capturedByte), .dispatchAction(dispatchAction),
        .deflectInterlock(deflectInterlock), .penActivity(penActivity), .entryType(entryType),
        .timingPulse(timingPulse), .actionStart(actionStart), .cursorCheck(cursorCheck),
        .regenHalt(regenHalt), .ringStep(ringStep), .runActive(runActive));
    deflect_model i_defl (.ref_clk(ref_clk), .startDeflect(startDeflect),
        .settleCycles(settleCycles), .deflectLoad(timingPulse[PULSE_DEFLECT_LOAD]),
        .deflectInterlock(deflectInterlock));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [PULSE_W-1:0] got, input logic [PULSE_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected pulse at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until ack is seen high at a rising edge
    task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        wbAdrI <= 13'(a);
        wbWeI <= we;
        wbDatI <= d;
        wbSelI <= 4'hF;
        wbCycI <= 1'b1;
        wbStbI <= 1'b1;
        for (i = 0; i < 16 && wbAckO !== 1'b1; i++) begin
            @(posedge ref_clk);
        end
        if (wbAckO !== 1'b1) begin
            fails++;
            give_verdict();
        end
        rd = wbDatO;
        wbCycI <= 1'b0;
        wbStbI <= 1'b0;
        wbWeI <= 1'b0;
    endtask
    task automatic wait_for(input int what, input int bound, input bit must);
        hit = 1'b0;
        for (waited = 0; waited < bound; waited++) begin
            case (what)
                0: hit = |timingPulse;
                1: hit = |actionStart;
                2: hit = cursorCheck;
                3: hit = regenHalt;
                default: hit = !runActive;
            endcase
            if (hit) break;
            @(posedge ref_clk);
        end
        if (must && !hit) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic do_reset;
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
    endtask
    initial begin
        do_reset();
        wb(REG_STATUS, 1'b0, 32'h0000_0000);
        chk_reg(rd, 32'h0000_0000);
        wb(REG_ARM, 1'b0, 32'h0000_0000);
        chk_reg(rd, 32'h0000_0000);
        wb(4'h2, 1'b0, 32'h0000_0000);
        chk_reg(rd, UNMAPPED_DATA);
        for (int n = 0; n < 32; n++) begin
            if (n >= PULSE_W || !PULSE_USED[n]) begin
                wb(REG_ARM, 1'b1, 32'(n));
                wb(REG_ARM, 1'b0, 32'h0000_0000);
                chk_reg(rd, 32'h0000_0000);
            end
        end
        for (int a = 1; a < 6; a++) begin
            do_reset();
            dispatchAction <= 3'(a);
            wb(REG_ARM, 1'b1, 32'(PULSE_BYTE_DISPATCH));
            wait_for(0, 40, 1'b1);
            chk_pin(timingPulse, 27'h000_0002);
            wait_for(1, 4, 1'b1);
            chk_reg(32'(actionStart), 32'(a));
        end
        do_reset();
        directWrite <= 1'b1;
        byteCaptured <= 1'b1;
        serviceFourth <= 1'b1;
        @(posedge ref_clk);
        serviceFourth <= 1'b0;
        wait_for(0, 40, 1'b1);
        chk_pin(timingPulse, 27'h000_0002);
        directWrite <= 1'b0;
        regenActive <= 1'b1;
        // bit 6 alone decides, so the other bits are set when it is clear
        for (int c = 0; c < 2; c++) begin
            do_reset();
            capturedByte <= (c == 1) ? 8'h40 : 8'hBF;
            wb(REG_ARM, 1'b1, 32'(PULSE_BYTE_DISPATCH));
            wait_for(2, 30, 1'b0);
            chk_reg(32'(hit), 32'(c));
        end
        for (int e = 0; e < 3; e++) begin
            do_reset();
            dispatchAction <= ACT_DEFLECT;
            entryType <= 2'(e);
            penActivity <= 1'b1;
            startDeflect <= 1'b1;
            @(posedge ref_clk);
            startDeflect <= 1'b0;
            wb(REG_ARM, 1'b1, 32'(PULSE_BYTE_DISPATCH));
            // regeneration arms the buffer read first, so the arm write is ignored
            wait_for(0, 40, 1'b1);
            chk_pin(timingPulse, 27'h000_0200);
            @(posedge ref_clk);
            wait_for(0, 40, 1'b1);
            chk_pin(timingPulse, 27'h000_0002);
            @(posedge ref_clk);
            wait_for(0, 40, 1'b1);
            chk_pin(timingPulse, 27'h000_0008);
            chk_reg(32'(regenHalt), 32'h0000_0000);
            wait_for(3, 120, 1'b1);
            chk_reg(32'(deflectInterlock), 32'h0000_0000);
            penActivity <= 1'b0;
            wb(REG_STATUS, 1'b0, 32'h0000_0000);
            chk_reg(rd & 32'h0000_0001, 32'h0000_0001);
            // one buffer read stepped the counter before the pen hit
            expAddr = ADDR_RESET + 14'h0001 - backBy[e];
            wb(REG_SENSE, 1'b0, 32'h0000_0000);
            chk_reg(rd & 32'h0000_3FFF, {18'h0_0000, expAddr});
            wb(REG_STATUS, 1'b1, 32'h0000_0001);
            wb(REG_CONTROL, 1'b1, 32'h0000_0004);
            wb(REG_STATUS, 1'b0, 32'h0000_0000);
            chk_reg(rd & 32'h0000_0021, 32'h0000_0000);
        end
        regenActive <= 1'b0;
        do_reset();
        wb(REG_ARM, 1'b1, 32'(PULSE_BUFFER_READ));
        wait_for(0, 40, 1'b1);
        chk_pin(timingPulse, 27'h000_0200);
        @(posedge ref_clk);
        wait_for(0, 60, 1'b1);
        chk_reg(32'(waited + 1), 32'h0000_0014);
        wb(REG_CONTROL, 1'b1, 32'h0000_0002);
        wait_for(4, 12, 1'b1);
        chk_reg(32'(runActive), 32'h0000_0000);
        do_reset();
        bufferWrite <= 1'b1;
        wb(REG_ARM, 1'b1, 32'(PULSE_BUFFER_READ));
        wait_for(0, 40, 1'b1);
        chk_reg(32'(runActive), 32'h0000_0001);
        wb(REG_ARM, 1'b1, 32'(PULSE_DEFLECT_WAIT));
        wb(REG_ARM, 1'b0, 32'h0000_0000);
        chk_reg(rd, 32'h0000_0002);
        byteStored <= 1'b1;
        @(posedge ref_clk);
        byteStored <= 1'b0;
        wait_for(4, 30, 1'b1);
        chk_reg(32'(runActive), 32'h0000_0000);
        give_verdict();
    end
endmodule
`default_nettype wire
